// File: core/drive_control_source_select.sv
// command source selection for a motor drive
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - level 2-wire judges levels only
// - one start closed runs; else stop
// - level mode restarts after reset or power
// - bus control word drives run state
// - panel/remote switch by key or terminal
// - source codes 0..4; defaults 1 and 0
// - closed select input picks source two when assigned
// - otherwise source one is used
// - source change obeyed immediately
// - tracking keeps run entering 3-wire
// - panel access codes 0..3
// - mode key toggles local/remote state
// - local reset setting gates stop-key reset
// - else reset by edge or bus link
// - stop key scope local or always
// - 3-wire start needs 2 ms pulse, stop closed
// - edge mode reset blocks until start opens
module drive_control_source_select
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic fwdStartInput,
  input wire logic revStartInput,
  input wire logic fwd3Input,
  input wire logic rev3Input,
  input wire logic stop3Input,
  input wire logic srcSelInput,
  input wire logic srcSelAssigned,
  input wire logic panelDiInput,
  input wire logic extResetInput,
  input wire logic powerReturn,
  input wire logic faultActive,
  input wire logic modeKey,
  input wire logic keyRun,
  input wire logic keyRev,
  input wire logic keyStop,
  input wire logic busLinkOk,
  input wire logic busRun,
  input wire logic busRev,
  input wire logic busReset,
  output logic runCmd,
  output logic revCmd,
  output logic localActive,
  output logic faultReset
);
  import drive_cmd_pkg::*;

  // ==========================================================
  // input synchronisers
  // pin levels, two stages
  logic [10:0] syncA_q;
  logic [10:0] syncB_q;
  wire logic [10:0] pinRaw = {fwdStartInput, revStartInput, fwd3Input,
    rev3Input, stop3Input, srcSelInput, panelDiInput, extResetInput,
    modeKey, keyStop, powerReturn};
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      syncA_q <= 11'h000;
      syncB_q <= 11'h000;
    end
    else
    begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
    end
  end
  wire logic fwdS = syncB_q[10];
  wire logic revS = syncB_q[9];
  wire logic fwd3S = syncB_q[8];
  wire logic rev3S = syncB_q[7];
  wire logic stop3S = syncB_q[6];
  wire logic selS = syncB_q[5];
  wire logic panelDiS = syncB_q[4];
  wire logic extRstS = syncB_q[3];
  wire logic modeS = syncB_q[2];
  wire logic stopKeyS = syncB_q[1];
  wire logic powerS = syncB_q[0];
  // previous synced levels for edge detection
  logic [10:0] prev_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prev_q <= 11'h000;
    else
      prev_q <= syncB_q;
  end
  wire logic [10:0] rise = syncB_q & ~prev_q;

  // ==========================================================
  // configuration registers
  logic [2:0] src1_q;
  logic [2:0] src2_q;
  logic track_q;
  logic [1:0] panel_q;
  logic resetAllow_q;
  logic [1:0] stopScope_q;
  wire logic wrSrc1 = regWr && (regAddr == REG_SRC1);
  wire logic wrSrc2 = regWr && (regAddr == REG_SRC2);
  wire logic wrCfg = regWr && (regAddr == REG_CFG);
  // register writes, defaults at reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      src1_q <= SRC1_RESET;
      src2_q <= SRC2_RESET;
      track_q <= TRACK_RESET;
      panel_q <= PANEL_RESET;
      resetAllow_q <= RESET_ALLOW_RESET;
      stopScope_q <= STOP_SCOPE_RESET;
    end
    else
    begin
      if (wrSrc1 && regWdata[2:0] <= 3'h4)
        src1_q <= regWdata[2:0];
      if (wrSrc2 && regWdata[2:0] <= 3'h4)
        src2_q <= regWdata[2:0];
      if (wrCfg)
      begin
        track_q <= regWdata[CFG_TRACK_BIT];
        panel_q <= regWdata[CFG_PANEL_LSB +: 2];
        resetAllow_q <= regWdata[CFG_RESET_BIT];
        stopScope_q <= regWdata[CFG_STOP_BIT] ? STOP_ALWAYS
          : STOP_SCOPE_RESET;
      end
    end
  end

  // ==========================================================
  // source and panel selection
  // source two only when assigned input closed
  wire logic useSrc2 = srcSelAssigned && selS;
  wire logic [2:0] activeSrc = useSrc2 ? src2_q : src1_q;
  logic local_q;
  // mode key toggles, di or fixed modes override
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      local_q <= 1'h0;
    else if (panel_q == PANEL_BUTTON && rise[2])
      local_q <= ~local_q;
  end
  wire logic panelOn = (panel_q == PANEL_ALWAYS) ||
    (panel_q == PANEL_BY_DI && panelDiS) ||
    (panel_q == PANEL_BUTTON && local_q);

  // ==========================================================
  // reset handling
  wire logic keyStopReset = resetAllow_q && rise[1];
  wire logic anyReset = faultActive && (keyStopReset || rise[3] ||
    (busLinkOk && busReset));
  wire logic stopKeyActive = stopKeyS &&
    (panelOn || stopScope_q == STOP_ALWAYS);

  // ==========================================================
  // per-variant requests
  // exactly one start closed gives run
  wire logic twoRun = fwdS ^ revS;
  // 3-wire start pulse width counter
  logic [15:0] pulseCnt_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pulseCnt_q <= 16'h0000;
    else if (!(fwd3S || rev3S))
      pulseCnt_q <= 16'h0000;
    else if (pulseCnt_q != 16'(MIN_PULSE_CYC))
      pulseCnt_q <= pulseCnt_q + 16'h0001;
  end
  wire logic pulseLong = pulseCnt_q == 16'(MIN_PULSE_CYC);
  wire logic threeStart = pulseLong && stop3S &&
    (fwd3S ^ rev3S);
  wire logic threeStop = !stop3S || (fwd3S && stop3S && rev3S);
  logic entered3_q;
  logic [2:0] lastSrc_q;
  wire logic srcChanged = activeSrc != lastSrc_q;

  // ==========================================================
  // run state machine
  run_state_t state_q;
  run_state_t state_d;
  logic rev_q;
  logic rev_d;
  always_comb
  begin
    state_d = state_q;
    rev_d = rev_q;
    if (panelOn)
    begin
      // remote inputs ignored in panel mode; stop key read after sync
      if (stopKeyS)
        state_d = ST_IDLE;
      else if (keyRun)
      begin
        state_d = ST_RUN;
        rev_d = keyRev;
      end
    end
    else if (stopKeyActive)
      state_d = ST_IDLE;
    else
    begin
      unique case (activeSrc)
        SRC_TWO_LEVEL:
        begin
          // levels only, restart after reset or mains
          state_d = twoRun ? ST_RUN : ST_IDLE;
          rev_d = revS;
        end
        SRC_TWO_EDGE:
        begin
          if (anyReset && twoRun)
            state_d = ST_BLOCKED;
          else if (state_q == ST_BLOCKED)
            state_d = twoRun ? ST_BLOCKED : ST_IDLE;
          else
          begin
            state_d = twoRun ? ST_RUN : ST_IDLE;
            rev_d = revS;
          end
        end
        SRC_THREE:
        begin
          if (srcChanged && !track_q)
            state_d = ST_IDLE;
          else if (threeStop)
            state_d = ST_IDLE;
          else if (threeStart)
          begin
            state_d = ST_RUN;
            rev_d = rev3S;
          end
        end
        SRC_BUS:
        begin
          state_d = (busLinkOk && busRun) ? ST_RUN : ST_IDLE;
          rev_d = busRev;
        end
        default: state_d = ST_IDLE;
      endcase
    end
    if (faultActive && state_d == ST_RUN)
      state_d = ST_IDLE;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      rev_q <= 1'h0;
      lastSrc_q <= SRC1_RESET;
      entered3_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      rev_q <= rev_d;
      lastSrc_q <= activeSrc;
      entered3_q <= srcChanged && activeSrc == SRC_THREE;
    end
  end

  // ==========================================================
  // outputs and read-back
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      runCmd <= 1'h0;
      revCmd <= 1'h0;
      localActive <= 1'h0;
      faultReset <= 1'h0;
      regRdata <= 8'h00;
    end
    else
    begin
      runCmd <= state_d == ST_RUN;
      revCmd <= rev_d;
      localActive <= panelOn;
      faultReset <= anyReset;
      unique case (regAddr)
        REG_SRC1: regRdata <= regRd ? {5'h00, src1_q} : 8'h00;
        REG_SRC2: regRdata <= regRd ? {5'h00, src2_q} : 8'h00;
        REG_CFG: regRdata <= regRd ? {3'h0, stopScope_q == STOP_ALWAYS,
          resetAllow_q, panel_q, track_q} : 8'h00;
        REG_STATUS: regRdata <= regRd ? {2'h0, useSrc2, panelOn,
          rev_q, state_q == ST_BLOCKED, state_q == ST_RUN, powerS}
          : 8'h00;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // assertions
  property p_level_two;
    @(posedge clk_sys) disable iff (rst)
    (!panelOn && !stopKeyS && !faultActive && activeSrc == SRC_TWO_LEVEL
      && twoRun) |=> runCmd;
  endproperty
  a_level_two: assert property (p_level_two)
    else $error("level mode did not run");
  property p_both_stop;
    @(posedge clk_sys) disable iff (rst)
    (!panelOn && activeSrc == SRC_TWO_LEVEL && fwdS && revS) |=> !runCmd;
  endproperty
  a_both_stop: assert property (p_both_stop)
    else $error("both starts closed but running");
  property p_panel_ignore;
    @(posedge clk_sys) disable iff (rst)
    (panelOn && !keyRun && state_q == ST_IDLE) |=> !runCmd;
  endproperty
  a_panel_ignore: assert property (p_panel_ignore)
    else $error("remote run in panel mode");
  property p_src_sel;
    @(posedge clk_sys) disable iff (rst)
    !srcSelAssigned |-> activeSrc == src1_q;
  endproperty
  a_src_sel: assert property (p_src_sel)
    else $error("source two without assignment");
  property p_blocked;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_BLOCKED && twoRun && activeSrc == SRC_TWO_EDGE
      && !panelOn) |=> !runCmd;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("restart after reset in edge mode");
  property p_reset_key;
    @(posedge clk_sys) disable iff (rst)
    (!resetAllow_q && !rise[3] && !(busLinkOk && busReset)) |=> !faultReset;
  endproperty
  a_reset_key: assert property (p_reset_key)
    else $error("reset by disallowed stop key");
  property p_always_panel;
    @(posedge clk_sys) disable iff (rst)
    panel_q == PANEL_ALWAYS |=> localActive;
  endproperty
  a_always_panel: assert property (p_always_panel)
    else $error("panel not active in always mode");
  property p_three_short;
    @(posedge clk_sys) disable iff (rst)
    (activeSrc == SRC_THREE && !pulseLong && state_q == ST_IDLE
      && !panelOn) |=> !runCmd;
  endproperty
  a_three_short: assert property (p_three_short)
    else $error("short pulse started drive");
  property p_stop_scope;
    @(posedge clk_sys) disable iff (rst)
    (stopKeyS && stopScope_q == STOP_ALWAYS) |=> !runCmd;
  endproperty
  a_stop_scope: assert property (p_stop_scope)
    else $error("stop key ignored");
  c_bus_run: cover property (@(posedge clk_sys) activeSrc == SRC_BUS
    && runCmd);
  c_blocked: cover property (@(posedge clk_sys) state_q == ST_BLOCKED);
  c_src_swap: cover property (@(posedge clk_sys) entered3_q);
endmodule : drive_control_source_select

// File: common/drive_cmd_pkg.sv
// shared constants and types for the command source selector
package drive_cmd_pkg;
  // source variants (remote_source_one_variant / two)
  typedef enum logic [2:0] {
    SRC_UNUSED = 3'h0,
    SRC_TWO_EDGE = 3'h1,
    SRC_THREE = 3'h2,
    SRC_TWO_LEVEL = 3'h3,
    SRC_BUS = 3'h4
  } src_variant_t;
  // panel access modes
  typedef enum logic [1:0] {
    PANEL_BUTTON = 2'h0,
    PANEL_LOCKED = 2'h1,
    PANEL_BY_DI = 2'h2,
    PANEL_ALWAYS = 2'h3
  } panel_access_t;
  // run state machine, gray along idle-run path
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_BLOCKED = 2'h3
  } run_state_t;
  // register indices
  localparam logic [3:0] REG_SRC1 = 4'h0;
  localparam logic [3:0] REG_SRC2 = 4'h1;
  localparam logic [3:0] REG_CFG = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  // field positions of REG_CFG
  localparam int CFG_TRACK_BIT = 0;
  localparam int CFG_PANEL_LSB = 1;
  localparam int CFG_RESET_BIT = 3;
  localparam int CFG_STOP_BIT = 4;
  // reset values, then the always stop scope code
  localparam logic [2:0] SRC1_RESET = 3'h1;
  localparam logic [2:0] SRC2_RESET = 3'h0;
  localparam logic TRACK_RESET = 1'h0;
  localparam logic [1:0] PANEL_RESET = 2'h0;
  localparam logic RESET_ALLOW_RESET = 1'h1;
  localparam logic [1:0] STOP_SCOPE_RESET = 2'h1;
  localparam logic [1:0] STOP_ALWAYS = 2'h2;
  // timing: minimum 3-wire start pulse
  localparam int CLK_HZ = 10000000;
  localparam int MIN_PULSE_US = 2000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_US * (CLK_HZ / 1000000));
endpackage : drive_cmd_pkg

// File: bench/drive_far_side.sv
// far side model: terminal contacts, keypad and fieldbus master
`timescale 1ns/1ps
module drive_far_side
(
  input wire logic clk_sys,
  output logic fwdStartInput = 1'b0,
  output logic revStartInput = 1'b0,
  output logic fwd3Input = 1'b0,
  output logic rev3Input = 1'b0,
  output logic stop3Input = 1'b0,
  output logic srcSelInput = 1'b0,
  output logic panelDiInput = 1'b0,
  output logic extResetInput = 1'b0,
  output logic modeKey = 1'b0,
  output logic keyRun = 1'b0,
  output logic keyRev = 1'b0,
  output logic keyStop = 1'b0,
  output logic busLinkOk = 1'b0,
  output logic busRun = 1'b0,
  output logic busRev = 1'b0,
  output logic busReset = 1'b0
);
  // ==========
  // 2-wire start contacts, moved together
  task automatic twoWire(input logic f, input logic r);
    @(posedge clk_sys);
    fwdStartInput <= f;
    revStartInput <= r;
  endtask : twoWire
  // key tap: 0 mode, 1 stop, 2 external reset; held 4 cycles
  task automatic tap(input logic [1:0] sel);
    @(posedge clk_sys);
    modeKey <= (sel == 2'h0);
    keyStop <= (sel == 2'h1);
    extResetInput <= (sel == 2'h2);
    repeat (4) @(posedge clk_sys);
    modeKey <= 1'b0;
    keyStop <= 1'b0;
    extResetInput <= 1'b0;
  endtask : tap
  // forward start pulse of n cycles on the 3-wire contact
  task automatic pulseFwd3(input int n);
    @(posedge clk_sys);
    fwd3Input <= 1'b1;
    repeat (n) @(posedge clk_sys);
    fwd3Input <= 1'b0;
  endtask : pulseFwd3
  // control word; reset only when asked, no automatic reset
  task automatic busWord(input logic [3:0] w);
    @(posedge clk_sys);
    busLinkOk <= w[3];
    busRun <= w[2];
    busRev <= w[1];
    busReset <= w[0];
  endtask : busWord
endmodule : drive_far_side

// File: bench/tb.sv
// self-checking bench for the command source selector
`timescale 1ns/1ps
module tb;
  import drive_cmd_pkg::*;
  // ==========
  // clock, reset, register port and config levels
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic srcSelAssigned = 1'b0;
  logic powerReturn = 1'b0;
  logic faultActive = 1'b0;
  logic [7:0] regRdata;
  logic runCmd, revCmd, localActive, faultReset;
  wire fwdStartInput, revStartInput, fwd3Input, rev3Input, stop3Input;
  wire srcSelInput, panelDiInput, extResetInput, modeKey, keyRun;
  wire keyRev, keyStop, busLinkOk, busRun, busRev, busReset;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int pulses = 0;
  int p0;
  logic [31:0] seed = 32'h00017455; // 95317
  drive_control_source_select u_dut
  (
    .clk_sys, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .fwdStartInput, .revStartInput, .fwd3Input, .rev3Input,
    .stop3Input, .srcSelInput, .srcSelAssigned, .panelDiInput,
    .extResetInput, .powerReturn, .faultActive, .modeKey, .keyRun,
    .keyRev, .keyStop, .busLinkOk, .busRun, .busRev, .busReset,
    .runCmd, .revCmd, .localActive, .faultReset
  );
  drive_far_side u_far
  (
    .clk_sys, .fwdStartInput, .revStartInput, .fwd3Input, .rev3Input,
    .stop3Input, .srcSelInput, .panelDiInput, .extResetInput, .modeKey,
    .keyRun, .keyRev, .keyStop, .busLinkOk, .busRun, .busRev, .busReset
  );
  // ==========
  // 100 ns clock; cycle ceiling and reset pulse count
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (faultReset === 1'b1) pulses++;
    if (cycles == 60000)
    begin
      num_errors++;
      final_report;
    end
  end
  // ==========
  // expectations and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // 2-wire: {run, reverse} from contact levels
  function automatic logic [1:0] twoExp(input logic f, input logic r);
    return {f ^ r, r & ~f};
  endfunction : twoExp
  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // read strobe one cycle, data checked in the following cycle
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk8("regRdata", e, regRdata);
  endtask : rchk
  // pins pass two flops; outputs are levels
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ==========
  // main sequence
  initial
  begin
    logic [7:0] d;
    logic [1:0] e;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(REG_SRC1, 8'h01);
    rchk(REG_SRC2, 8'h00);
    rchk(REG_CFG, 8'h08);
    rchk(4'hF, 8'h00);
    // every source code, then an out-of-range one that is refused
    for (int i = 0; i < 6; i++)
    begin
      wr(REG_SRC1, i[7:0]);
      rchk(REG_SRC1, (i < 5) ? i[7:0] : 8'h04);
    end
    // level 2-wire: corner table then random contacts
    wr(REG_SRC1, 8'h03);
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      d = (i < 4) ? i[7:0] : seed[7:0];
      u_far.twoWire(d[0], d[1]);
      e = twoExp(d[0], d[1]);
      settle;
      chk1("runCmd", e[1], runCmd);
      if (e[1]) chk1("revCmd", e[0], revCmd);
    end
    // level mode restarts after fault clears and mains return
    u_far.twoWire(1'b1, 1'b0);
    faultActive <= 1'b1;
    settle;
    chk1("runCmd", 1'b0, runCmd);
    faultActive <= 1'b0;
    powerReturn <= 1'b1;
    settle;
    chk1("runCmd", 1'b1, runCmd);
    rchk(REG_STATUS, 8'h03);
    // edge mode: reset with start closed blocks until it opens
    wr(REG_SRC1, 8'h01);
    u_far.twoWire(1'b0, 1'b0);
    settle;
    u_far.twoWire(1'b1, 1'b0);
    faultActive <= 1'b1;
    settle;
    // fault cleared by an external reset edge while start is closed
    u_far.tap(2'h2);
    faultActive <= 1'b0;
    settle;
    chk1("runCmd", 1'b0, runCmd);
    rchk(REG_STATUS, 8'h05);
    u_far.twoWire(1'b0, 1'b0);
    settle;
    u_far.twoWire(1'b1, 1'b0);
    settle;
    chk1("runCmd", 1'b1, runCmd);
    // stop key in remote: local-only scope, then always (edge mode)
    for (int i = 0; i < 2; i++)
    begin
      wr(REG_CFG, (i == 0) ? 8'h08 : 8'h18);
      u_far.keyStop <= 1'b1;
      settle;
      chk1("runCmd", i == 0, runCmd);
      u_far.keyStop <= 1'b0;
    end
    // fault reset: stop key allowed, refused, external edge, bus
    faultActive <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CFG, (i == 0) ? 8'h08 : 8'h00);
      p0 = pulses;
      if (i < 3) u_far.tap((i < 2) ? 2'h1 : 2'h2);
      else u_far.busWord(4'h9);
      u_far.busWord(4'h8);
      settle;
      chk1("faultReset", i != 1, pulses > p0);
    end
    faultActive <= 1'b0;
    // bus control word drives run and direction
    wr(REG_SRC1, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      u_far.busWord({1'b1, i[1], i[0], 1'b0});
      settle;
      chk1("runCmd", i[1], runCmd);
      if (i[1]) chk1("revCmd", i[0], revCmd);
    end
    // source select: bus on source one, level on source two
    u_far.busWord(4'h8);
    wr(REG_SRC2, 8'h03);
    for (int i = 0; i < 5; i++)
    begin
      {srcSelAssigned, u_far.srcSelInput} <= i[1:0];
      settle;
      chk1("runCmd", i == 3, runCmd);
    end
    // tracking into a 3-wire source keeps or drops the run
    wr(REG_SRC1, 8'h03);
    wr(REG_SRC2, 8'h02);
    u_far.stop3Input <= 1'b1;
    srcSelAssigned <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(REG_CFG, (i == 0) ? 8'h09 : 8'h08);
      u_far.srcSelInput <= 1'b0;
      settle;
      u_far.srcSelInput <= 1'b1;
      settle;
      chk1("runCmd", i == 0, runCmd);
    end
    // 3-wire: short pulse ignored, full pulse starts, stop opens
    u_far.pulseFwd3(100);
    settle;
    chk1("runCmd", 1'b0, runCmd);
    u_far.pulseFwd3(MIN_PULSE_CYC + 10);
    settle;
    chk1("runCmd", 1'b1, runCmd);
    chk1("revCmd", 1'b0, revCmd);
    // full reverse pulse turns the run around
    u_far.rev3Input <= 1'b1;
    repeat (MIN_PULSE_CYC + 10) @(posedge clk_sys);
    u_far.rev3Input <= 1'b0;
    settle;
    chk1("runCmd", 1'b1, runCmd);
    chk1("revCmd", 1'b1, revCmd);
    u_far.stop3Input <= 1'b0;
    settle;
    chk1("runCmd", 1'b0, runCmd);
    // panel by key: remote ignored, keypad obeyed, toggled back
    u_far.tap(2'h0);
    // remote level source wants to run once panel mode is on
    u_far.srcSelInput <= 1'b0;
    settle;
    chk1("localActive", 1'b1, localActive);
    chk1("runCmd", 1'b0, runCmd);
    u_far.keyRun <= 1'b1;
    u_far.keyRev <= 1'b1;
    settle;
    chk1("runCmd", 1'b1, runCmd);
    chk1("revCmd", 1'b1, revCmd);
    u_far.keyRun <= 1'b0;
    u_far.keyRev <= 1'b0;
    u_far.tap(2'h0);
    settle;
    chk1("localActive", 1'b0, localActive);
    chk1("runCmd", 1'b1, runCmd);
    chk1("revCmd", 1'b0, revCmd);
    // locked, by digital input, always active
    wr(REG_CFG, 8'h0A);
    u_far.tap(2'h0);
    settle;
    chk1("localActive", 1'b0, localActive);
    wr(REG_CFG, 8'h0C);
    u_far.panelDiInput <= 1'b1;
    settle;
    chk1("localActive", 1'b1, localActive);
    u_far.panelDiInput <= 1'b0;
    wr(REG_CFG, 8'h0E);
    settle;
    chk1("localActive", 1'b1, localActive);
    final_report;
  end
endmodule : tb
